// ==== hw/lsw_switch_ctrl.sv ====
`include "lsw_regs.svh"

// Summary of operation
// R1: the output carries the four fast channels of source A or source B as picked by the select bit.
// R2: the side-line group reaching the common lines follows its own select bit.
// R3: all four fast channels are handled by identical logic, so any may carry the pixel clock.
// R4: each fast input whose pulse bit is set loses its termination for about 100 ms per switch.
// R5: the global termination-off bit removes every input termination; default is connected.
// R6: each of the eight fast inputs has its own 6 dB / 12 dB boost bit.
// R7: one bit switches all output terminations together, on after reset.
// R8: clearing the switch enable bit tristates every fast output.
// R9: the current bit picks 20 mA (default) or 10 mA; 10 mA is for external-only termination.
// R10: software keeps outputs disabled when no output termination exists at all.
// R11: a two-bit field picks one of four output pre-emphasis levels.
// R12: the slave address is fixed upper six bits with the low bit from the address pin.
// R13: the active-low configuration reset restores all defaults and selects source A.
// R14: writes inside an update window do not restart it; the last value lands at its end.
// R15: a source change moves all four output channels at once, never leaving them mixed.
module lsw_switch_ctrl #(
  parameter int TERM_PULSE_CYC   = `LSW_TERM_PULSE_MS * `LSW_CLK_KHZ,
  parameter int SWITCH_DELAY_CYC = `LSW_SWITCH_DELAY_US * (`LSW_CLK_KHZ / 1000),
  parameter int UPDATE_DELAY_CYC = `LSW_UPDATE_DELAY_US * (`LSW_CLK_KHZ / 1000)
) (
  input  wire logic                         core_clk,
  input  wire logic                         sys_rst,
  input  wire logic                         cfg_rst_n,
  input  wire logic                         addr_sel_pin,
  input  wire logic [7:0]                   avs_address,
  input  wire logic                         avs_read,
  input  wire logic                         avs_write,
  input  wire logic [31:0]                  avs_writedata,
  input  wire logic [3:0]                   avs_byteenable,
  output logic      [31:0]                  avs_readdata,
  output logic                              avs_waitrequest,
  output lsw_pkg::lsw_analog_ctrl_type      analog_ctrl
);
  import lsw_pkg::*;

  // ----------------------------------------------------------------
  // reset value lookup, shared by shadow registers and windows
  // ----------------------------------------------------------------
  function automatic logic [7:0] lsw_reset_val(input int idx);
    logic [7:0] val;
    val = 8'h00;
    case (idx)
      `LSW_IDX_FAST_MODES: val = `LSW_RST_FAST_MODES;
      `LSW_IDX_SIDE_MODES: val = `LSW_RST_SIDE_MODES;
      `LSW_IDX_TERM_PULSE: val = `LSW_RST_TERM_PULSE;
      `LSW_IDX_RX_SET:     val = `LSW_RST_RX_SET;
      `LSW_IDX_RX_BOOST:   val = `LSW_RST_RX_BOOST;
      `LSW_IDX_TX_SET:     val = `LSW_RST_TX_SET;
      default: val = 8'h00;
    endcase
    return val;
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic cfg_rst_n_meta;
  logic cfg_rst_n_sync;
  logic addr_sel_meta;
  logic addr_sel_sync;

  // pins are asynchronous to core_clk, so two flops before any use
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cfg_rst_n_meta <= 1'b1;
      cfg_rst_n_sync <= 1'b1;
      addr_sel_meta  <= 1'b0;
      addr_sel_sync  <= 1'b0;
    end else begin
      cfg_rst_n_meta <= cfg_rst_n;
      cfg_rst_n_sync <= cfg_rst_n_meta;
      addr_sel_meta  <= addr_sel_pin;
      addr_sel_sync  <= addr_sel_meta;
    end
  end

  wire logic       cfg_reset = ~cfg_rst_n_sync;
  wire logic [6:0] own_addr  = {`LSW_ADDR_UPPER, addr_sel_sync}; // R12

  // ----------------------------------------------------------------
  // bus slave: one wait cycle per access
  // ----------------------------------------------------------------
  logic ack;

  wire logic                 bus_req    = avs_read ^ avs_write;
  wire logic                 word_ok    = (avs_address[1:0] == 2'b00);
  wire logic [`LSW_IDX_W-1:0] acc_idx   = avs_address[`LSW_IDX_W+1:2];
  wire logic                 upper_zero = (avs_address[7:`LSW_IDX_W+2] == '0);
  wire logic                 idx_rw     = word_ok && upper_zero
                                          && (acc_idx < `LSW_NUM_RW_REGS);
  wire logic                 idx_id     = word_ok && upper_zero
                                          && (acc_idx == `LSW_IDX_OWN_ADDR);
  wire logic                 wr_take    = avs_write && ack && avs_byteenable[0];

  assign avs_waitrequest = bus_req && !ack;

  // ack rises one cycle after the request and drops after the answer
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ack <= 1'b0;
    end else begin
      ack <= bus_req && !ack;
    end
  end

  // ----------------------------------------------------------------
  // shadow registers and update windows
  // ----------------------------------------------------------------
  logic [7:0] shadow  [`LSW_NUM_RW_REGS];
  logic [7:0] applied [`LSW_NUM_RW_REGS];
  logic [`LSW_NUM_RW_REGS-1:0] reg_wr;
  logic [`LSW_NUM_RW_REGS-1:0] reg_busy;

  genvar gi;
  generate
    for (gi = 0; gi < `LSW_NUM_RW_REGS; gi++) begin : g_reg
      assign reg_wr[gi] = wr_take && idx_rw && (acc_idx == gi[`LSW_IDX_W-1:0]);

      // software sees the last written byte, the datapath the applied one
      always_ff @(posedge core_clk) begin
        if (sys_rst || cfg_reset) begin
          shadow[gi] <= lsw_reset_val(gi); // R13
        end else if (reg_wr[gi]) begin
          shadow[gi] <= avs_writedata[7:0];
        end
      end

      lsw_update_window #(
        .DELAY_CYC (gi == 0 ? SWITCH_DELAY_CYC : UPDATE_DELAY_CYC),
        .RESET_VAL (lsw_reset_val(gi))
      ) u_window (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .restart  (cfg_reset),
        .wr       (reg_wr[gi]),
        .wdata    (avs_writedata[7:0]),
        .applied  (applied[gi]),
        .busy     (reg_busy[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  wire logic [7:0] rd_rw   = idx_rw ? shadow[acc_idx] : 8'h00;
  wire logic [7:0] rd_byte = idx_id ? {1'b0, own_addr} : rd_rw; // R12

  // loaded in the wait cycle so it stands when waitrequest drops
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack) begin
      avs_readdata <= {24'h00_0000, rd_byte};
    end
  end

  // ----------------------------------------------------------------
  // applied fields
  // ----------------------------------------------------------------
  wire logic [7:0] fast_modes = applied[`LSW_IDX_FAST_MODES];
  wire logic [7:0] side_modes = applied[`LSW_IDX_SIDE_MODES];
  wire logic [7:0] tx_set     = applied[`LSW_IDX_TX_SET];
  wire logic       fast_sel   = fast_modes[`LSW_BIT_SELECT];
  wire logic       term_off   = applied[`LSW_IDX_RX_SET][`LSW_BIT_TERM_OFF];
  wire logic [7:0] pulse_en   = applied[`LSW_IDX_TERM_PULSE];

  // ----------------------------------------------------------------
  // termination pulse after a source switch
  // ----------------------------------------------------------------
  logic        fast_sel_prev;
  logic [31:0] pulse_cnt;

  wire logic source_switch = (fast_sel != fast_sel_prev);
  wire logic pulse_active  = (pulse_cnt != 32'h0);

  // every applied source change restarts the 100 ms release
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      fast_sel_prev <= 1'b0;
      pulse_cnt     <= 32'h0;
    end else begin
      fast_sel_prev <= fast_sel;
      if (source_switch) begin
        pulse_cnt <= TERM_PULSE_CYC; // R4
      end else if (pulse_active) begin
        pulse_cnt <= pulse_cnt - 32'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // next analog controls
  // ----------------------------------------------------------------
  lsw_analog_ctrl_type next_ctrl;
  logic [7:0]          next_term;

  // one select flop fans out to all channels, so they cannot disagree
  generate
    for (gi = 0; gi < 4; gi++) begin : g_chan
      assign next_ctrl.fast_route_b[gi] = fast_sel; // R1 R3 R15
    end
    for (gi = 0; gi < 8; gi++) begin : g_term
      assign next_term[gi] = !term_off && !(pulse_active && pulse_en[gi]); // R4 R5
    end
  endgenerate

  assign next_ctrl.fast_out_tristate   = !fast_modes[`LSW_BIT_ENABLE]; // R8
  assign next_ctrl.side_line_route_b   = side_modes[`LSW_BIT_SELECT]; // R2
  assign next_ctrl.side_line_enable    = side_modes[`LSW_BIT_ENABLE];
  assign next_ctrl.input_term_connect  = next_term;
  assign next_ctrl.input_boost_12db    = applied[`LSW_IDX_RX_BOOST]; // R6
  assign next_ctrl.output_term_on      = tx_set[`LSW_BIT_OUT_TERM]; // R7
  assign next_ctrl.output_current_20ma = tx_set[`LSW_BIT_CUR_20MA]; // R9
  assign next_ctrl.output_preemphasis_level = tx_set[`LSW_PE_MSB:`LSW_PE_LSB]; // R11

  // outputs come from flops to keep the analog controls glitch free
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      analog_ctrl <= '0;
    end else begin
      analog_ctrl <= next_ctrl;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_switch_seen;
    !sys_rst && source_switch;
  endsequence

  sequence s_pulse_held;
    (analog_ctrl.input_term_connect & $past(pulse_en)) == 8'h00;
  endsequence

  chk_route_together: assert property (@(posedge core_clk) disable iff (sys_rst) // R15
    analog_ctrl.fast_route_b == 4'h0 || analog_ctrl.fast_route_b == 4'hF)
    else $error("output channels routed from mixed sources");

  chk_route_follow: assert property (@(posedge core_clk) disable iff (sys_rst) // R1
    ##1 analog_ctrl.fast_route_b[0] == $past(fast_sel))
    else $error("output route does not follow applied select");

  chk_side_route: assert property (@(posedge core_clk) disable iff (sys_rst) // R2
    ##1 analog_ctrl.side_line_route_b == $past(side_modes[`LSW_BIT_SELECT]))
    else $error("side-line route does not follow its select");

  chk_pulse_start: assert property (@(posedge core_clk) disable iff (sys_rst || cfg_reset) // R4
    s_switch_seen |=> pulse_cnt == TERM_PULSE_CYC ##1 s_pulse_held)
    else $error("termination not released after source switch");

  chk_term_off_all: assert property (@(posedge core_clk) disable iff (sys_rst) // R5
    term_off |=> analog_ctrl.input_term_connect == 8'h00)
    else $error("input termination connected while global off");

  chk_term_default: assert property (@(posedge core_clk) disable iff (sys_rst) // R5
    !sys_rst && !term_off && !pulse_active |=> analog_ctrl.input_term_connect == 8'hFF)
    else $error("input termination missing in default state");

  chk_boost_map: assert property (@(posedge core_clk) disable iff (sys_rst) // R6
    ##1 analog_ctrl.input_boost_12db == $past(applied[`LSW_IDX_RX_BOOST]))
    else $error("boost levels do not follow register");

  chk_tx_fields: assert property (@(posedge core_clk) disable iff (sys_rst) // R7 R9 R11
    !sys_rst |=> {analog_ctrl.output_term_on, analog_ctrl.output_current_20ma,
         analog_ctrl.output_preemphasis_level}
        == {$past(tx_set[`LSW_BIT_OUT_TERM]), $past(tx_set[`LSW_BIT_CUR_20MA]),
            $past(tx_set[`LSW_PE_MSB:`LSW_PE_LSB])})
    else $error("transmitter controls do not follow register");

  chk_tristate: assert property (@(posedge core_clk) disable iff (sys_rst) // R8
    !fast_modes[`LSW_BIT_ENABLE] |=> analog_ctrl.fast_out_tristate)
    else $error("outputs driven while switch disabled");

  chk_own_addr: assert property (@(posedge core_clk) disable iff (sys_rst) // R12
    avs_read && !ack && idx_id |=> avs_readdata[6:0] == {`LSW_ADDR_UPPER, $past(addr_sel_sync)})
    else $error("slave address readback wrong");

  chk_cfg_reset: assert property (@(posedge core_clk) disable iff (sys_rst) // R13
    cfg_reset |=> !fast_sel && shadow[0] == `LSW_RST_FAST_MODES ##1 !fast_sel)
    else $error("configuration reset did not select source A");

  // the enable bit is watched both ways, so a stuck tristate cannot hide
  chk_outputs_enabled: assert property (@(posedge core_clk) disable iff (sys_rst) // R8
    !sys_rst && fast_modes[`LSW_BIT_ENABLE] |=> !analog_ctrl.fast_out_tristate)
    else $error("outputs tristated while switch enabled");

  chk_side_enable: assert property (@(posedge core_clk) disable iff (sys_rst) // R2
    !sys_rst |=> analog_ctrl.side_line_enable == $past(side_modes[`LSW_BIT_ENABLE]))
    else $error("side-line enable does not follow its register");

  // a write to an idle register must open its update window
  chk_window_open: assert property (@(posedge core_clk) disable iff (sys_rst || cfg_reset) // R14
    |(reg_wr & ~reg_busy) |=> (reg_busy & $past(reg_wr & ~reg_busy)) == $past(reg_wr & ~reg_busy))
    else $error("idle register write did not open a window");

  chk_bus_answer: assert property (@(posedge core_clk) disable iff (sys_rst)
    bus_req && !ack |=> !avs_waitrequest)
    else $error("bus answer not given after one wait cycle");

endmodule // lsw_switch_ctrl

// ==== hw/lsw_update_window.sv ====
`include "lsw_regs.svh"

// holds a written byte and applies it with a fixed update window
module lsw_update_window #(
  parameter int         DELAY_CYC = 16,
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       restart,
  input  wire logic       wr,
  input  wire logic [7:0] wdata,
  output logic      [7:0] applied,
  output logic            busy
);
  import lsw_pkg::*;

  lsw_win_state_type state;
  logic [31:0]       cnt;
  logic [7:0]        pending;
  wire logic         win_end = (state == LSW_WIN_HOLD) && (cnt == 32'h1);
  wire logic [7:0]   latest  = wr ? wdata : pending;

  assign busy = (state == LSW_WIN_HOLD);

  // ----------------------------------------------------------------
  // window sequencing
  // ----------------------------------------------------------------
  // writes inside the window only refresh the pending byte, never the count
  always_ff @(posedge core_clk) begin
    if (sys_rst || restart) begin
      state   <= LSW_WIN_HOLD;
      cnt     <= DELAY_CYC;
      pending <= RESET_VAL;
      applied <= RESET_VAL;
    end else begin
      unique case (state)
        LSW_WIN_IDLE: begin
          if (wr) begin
            applied <= wdata; // R14
            pending <= wdata;
            cnt     <= DELAY_CYC;
            state   <= LSW_WIN_HOLD;
          end
        end
        LSW_WIN_HOLD: begin
          pending <= latest; // R14
          cnt     <= cnt - 32'h1;
          if (win_end) begin
            applied <= latest; // R14
            state   <= LSW_WIN_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_write_in_window;
    busy && !win_end && wr;
  endsequence

  chk_window_no_apply: assert property (@(posedge core_clk) disable iff (sys_rst || restart) // R14
    s_write_in_window |=> $stable(applied) && busy)
    else $error("write inside update window changed applied value");

  chk_idle_immediate: assert property (@(posedge core_clk) disable iff (sys_rst || restart) // R14
    !busy && wr |=> applied == $past(wdata) && busy)
    else $error("write after window did not apply at once");

  chk_window_end: assert property (@(posedge core_clk) disable iff (sys_rst || restart) // R14
    win_end |=> applied == $past(latest) && !busy)
    else $error("window end did not apply last written value");

endmodule // lsw_update_window

// ==== include/lsw_pkg.sv ====
package lsw_pkg;

  // applied settings that drive the analog datapath
  typedef struct packed {
    logic [3:0] fast_route_b;      // per output channel: 1 = source B
    logic       fast_out_tristate;
    logic       side_line_route_b;
    logic       side_line_enable;
    logic [7:0] input_term_connect; // A0..A3 then B0..B3
    logic [7:0] input_boost_12db;
    logic       output_term_on;
    logic       output_current_20ma;
    logic [1:0] output_preemphasis_level;
  } lsw_analog_ctrl_type;

  typedef enum logic [0:0] {LSW_WIN_IDLE, LSW_WIN_HOLD} lsw_win_state_type;

endpackage

// ==== include/lsw_regs.svh ====
`ifndef LSW_REGS_SVH
`define LSW_REGS_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define LSW_IDX_FAST_MODES  3'h0
`define LSW_IDX_SIDE_MODES  3'h1
`define LSW_IDX_TERM_PULSE  3'h2
`define LSW_IDX_RX_SET      3'h3
`define LSW_IDX_RX_BOOST    3'h4
`define LSW_IDX_TX_SET      3'h5
`define LSW_IDX_OWN_ADDR    3'h6
`define LSW_NUM_RW_REGS     6
`define LSW_IDX_W           3

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define LSW_BIT_ENABLE      6
`define LSW_BIT_SELECT      0
`define LSW_BIT_TERM_OFF    0
`define LSW_BIT_OUT_TERM    3
`define LSW_BIT_CUR_20MA    2
`define LSW_PE_MSB          1
`define LSW_PE_LSB          0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define LSW_RST_FAST_MODES  8'h40
`define LSW_RST_SIDE_MODES  8'h40
`define LSW_RST_TERM_PULSE  8'h00
`define LSW_RST_RX_SET      8'h00
`define LSW_RST_RX_BOOST    8'h00
`define LSW_RST_TX_SET      8'h0C

// ----------------------------------------------------------------
// slave address and timing
// ----------------------------------------------------------------
`define LSW_ADDR_UPPER      6'h24
`define LSW_CLK_KHZ         250000
`define LSW_TERM_PULSE_MS   100
`define LSW_SWITCH_DELAY_US 200
`define LSW_UPDATE_DELAY_US 20

`endif

// ==== verification/lsw_bus_master.sv ====
// ----------------------------------------------------------------
// register bus master standing in for the serial controller
// ----------------------------------------------------------------
module lsw_bus_master (
  input  wire logic        core_clk,
  input  wire logic        avs_waitrequest,
  input  wire logic [31:0] avs_readdata,
  output logic      [7:0]  avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic      [31:0] avs_writedata,
  output logic      [3:0]  avs_byteenable
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus from time zero, byte lane 0 always enabled
  initial begin
    avs_address    = 8'h00;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h0000_0000;
    avs_byteenable = 4'hF;
  end

  // one access: request held until waitrequest seen low at an edge
  // no fixed latency assumed; the bench watchdog cuts a hang short
  task automatic access(input logic rd, input logic [7:0] addr, input logic [7:0] wd,
                        output logic [7:0] rdata);
    @(posedge core_clk);
    avs_address   <= addr;
    avs_read      <= rd;
    avs_write     <= !rd;
    avs_writedata <= {24'h00_0000, wd};
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    rdata = avs_readdata[7:0];
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask
endmodule // lsw_bus_master

// ==== verification/tb_lsw_switch_ctrl.sv ====
// ----------------------------------------------------------------
// self-checking bench for the switch configuration block
// ----------------------------------------------------------------
module tb_lsw_switch_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import lsw_pkg::*;

  localparam int PULSE = 20;

  logic                core_clk     = 1'b0;
  logic                sys_rst      = 1'b1;
  logic                cfg_rst_n    = 1'b1;
  logic                addr_sel_pin = 1'b0;
  logic [7:0]          avs_address;
  logic                avs_read;
  logic                avs_write;
  logic [31:0]         avs_writedata;
  logic [3:0]          avs_byteenable;
  logic [31:0]         avs_readdata;
  logic                avs_waitrequest;
  lsw_analog_ctrl_type analog_ctrl;
  lsw_analog_ctrl_type dflt;
  lsw_analog_ctrl_type exp_ctrl;
  int                  failures    = 0;
  int                  check_count = 0;
  int                  cnt;
  logic [7:0]          rst_vals [6] = '{8'h40, 8'h40, 8'h00, 8'h00, 8'h00, 8'h0C};

  // 250 MHz core clock
  always #2 core_clk = ~core_clk;

  lsw_switch_ctrl #(
    .TERM_PULSE_CYC   (PULSE),
    .SWITCH_DELAY_CYC (8),
    .UPDATE_DELAY_CYC (4)
  ) u_lsw_switch_ctrl (
    .core_clk        (core_clk),
    .sys_rst         (sys_rst),
    .cfg_rst_n       (cfg_rst_n),
    .addr_sel_pin    (addr_sel_pin),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .analog_ctrl     (analog_ctrl)
  );

  lsw_bus_master u_lsw_bus_master (
    .core_clk        (core_clk),
    .avs_waitrequest (avs_waitrequest),
    .avs_readdata    (avs_readdata),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // the control struct is narrower than a word, so widen it on purpose
  task automatic check_ctrl(input lsw_analog_ctrl_type got, input lsw_analog_ctrl_type exp);
    check(32'(got), 32'(exp));
  endtask

  task automatic wr(input logic [2:0] idx, input logic [7:0] d);
    logic [7:0] unused;
    u_lsw_bus_master.access(1'b0, {3'h0, idx, 2'h0}, d, unused);
  endtask

  task automatic rd_chk(input logic [2:0] idx, input logic [7:0] exp);
    logic [7:0] got;
    u_lsw_bus_master.access(1'b1, {3'h0, idx, 2'h0}, 8'h00, got);
    check({24'h0, got}, {24'h0, exp});
  endtask

  // long enough for any update window and synchroniser to finish
  task automatic settle();
    repeat (40) @(posedge core_clk);
    #1;
  endtask

  task automatic finish_test();
    if (failures == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // watchdog: tests need well under 3000 cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    dflt                     = '0;
    dflt.side_line_enable    = 1'b1;
    dflt.input_term_connect  = 8'hFF;
    dflt.output_term_on      = 1'b1;
    dflt.output_current_20ma = 1'b1;
    exp_ctrl                 = dflt;
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    settle();
    check_ctrl(analog_ctrl, dflt);
    for (int i = 0; i < 6; i++) rd_chk(i[2:0], rst_vals[i]);
    rd_chk(3'h6, 8'h48);
    addr_sel_pin <= 1'b1;
    settle();
    rd_chk(3'h6, 8'h49);
    // read-only and unmapped places ignore writes
    wr(3'h6, 8'hFF);
    wr(3'h7, 8'hFF);
    rd_chk(3'h6, 8'h49);
    rd_chk(3'h7, 8'h00);
    settle();
    check_ctrl(analog_ctrl, exp_ctrl);
    // outputs parked before terminations are touched
    wr(3'h0, 8'h00);
    settle();
    exp_ctrl.fast_out_tristate = 1'b1;
    check_ctrl(analog_ctrl, exp_ctrl);
    // first write lands at once, second inside the window waits
    for (int i = 0; i < 4; i++) begin
      wr(3'h5, {6'h00, i[1:0]});
      wr(3'h5, 8'h0C);
      #1;
      exp_ctrl.output_term_on           = 1'b0;
      exp_ctrl.output_current_20ma      = 1'b0;
      exp_ctrl.output_preemphasis_level = i[1:0];
      check_ctrl(analog_ctrl, exp_ctrl);
      settle();
      exp_ctrl.output_term_on           = 1'b1;
      exp_ctrl.output_current_20ma      = 1'b1;
      exp_ctrl.output_preemphasis_level = 2'h0;
      check_ctrl(analog_ctrl, exp_ctrl);
    end
    wr(3'h1, 8'h01);
    settle();
    exp_ctrl.side_line_route_b = 1'b1;
    exp_ctrl.side_line_enable  = 1'b0;
    check_ctrl(analog_ctrl, exp_ctrl);
    wr(3'h4, 8'hA5);
    settle();
    exp_ctrl.input_boost_12db = 8'hA5;
    check_ctrl(analog_ctrl, exp_ctrl);
    wr(3'h3, 8'h01);
    settle();
    check({24'h0, analog_ctrl.input_term_connect}, 32'h0);
    wr(3'h3, 8'h00);
    settle();
    check_ctrl(analog_ctrl, exp_ctrl);
    // source switch with pulse on the A inputs only
    wr(3'h2, 8'h0F);
    settle();
    wr(3'h0, 8'h41);
    cnt = 0;
    for (int n = 0; n < 80; n++) begin
      @(posedge core_clk);
      #1;
      if (analog_ctrl.input_term_connect === 8'hF0) cnt++;
      else check({24'h0, analog_ctrl.input_term_connect}, 32'hFF);
      if (analog_ctrl.fast_route_b !== 4'h0) check({28'h0, analog_ctrl.fast_route_b}, 32'hF);
    end
    check(cnt, PULSE);
    exp_ctrl.fast_route_b      = 4'hF;
    exp_ctrl.fast_out_tristate = 1'b0;
    check_ctrl(analog_ctrl, exp_ctrl);
    rd_chk(3'h0, 8'h41);
    rd_chk(3'h2, 8'h0F);
    // configuration pin brings every setting home, source A
    cfg_rst_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    cfg_rst_n <= 1'b1;
    settle();
    check_ctrl(analog_ctrl, dflt);
    rd_chk(3'h0, 8'h40);
    rd_chk(3'h4, 8'h00);
    finish_test();
  end
endmodule // tb_lsw_switch_ctrl
